// file: hw/ssp_shift.sv
// serial shift engine: pin sync, sck edge detect, byte framing
`default_nettype none
module ssp_shift (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link pins
   input wire logic sck,
   input wire logic mosi,
   // towards the decoder
   ssp_lnk_if.eng lnk
);
   ssp_pkg::ssp_sh_t r;
   ssp_pkg::ssp_sh_t n;
   logic rise;
   logic fall;

   // edges seen on the second sync stage only; sck phases of two or more
   // clocks keep every edge visible
   assign rise = r.sck_s & ~r.sck_d;
   assign fall = ~r.sck_s & r.sck_d;

   // next state
   always_comb begin
      n = r;
      n.sck_m = sck;
      n.sck_s = r.sck_m;
      n.sck_d = r.sck_s;
      n.mosi_m = mosi;
      n.mosi_s = r.mosi_m;
      n.vld = 1'b0;
      if (lnk.clr) begin
         n.bitc = 3'd0;
         n.idx = 2'd0;
         n.miso = 1'b0;
      end else begin
         if (rise) begin
            n.sh_in = {r.sh_in[6:0], r.mosi_s};
            n.bitc = r.bitc + 3'd1;
            if (r.bitc == 3'd7) begin
               n.vld = 1'b1;
               n.rx = {r.sh_in[6:0], r.mosi_s};
               n.idx_o = r.idx;
               n.idx = r.idx + 2'd1; // four bytes per instruction
            end
         end
         if (fall) begin
            // a new byte starts with its msb
            if (r.bitc == 3'd0) begin
               n.miso = lnk.tx_byte[7];
               n.sh_out = {lnk.tx_byte[6:0], 1'b0};
            end else begin
               n.miso = r.sh_out[7];
               n.sh_out = {r.sh_out[6:0], 1'b0};
            end
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign lnk.byte_vld = r.vld;
   assign lnk.byte_idx = r.idx_o;
   assign lnk.rx_byte = r.rx;
   assign lnk.miso = r.miso;
endmodule
`default_nettype wire

// file: hw/ssp_top.sv
// serial programming port: decoder, memories, self-timed writes, apb registers
`include "ssp_defs.svh"
`default_nettype none
module ssp_top #(
   parameter int PAGE_WAIT_US = `SSP_T_PAGE_US,
   parameter int EEP_WAIT_US = `SSP_T_EEP_US,
   parameter int ERASE_WAIT_US = `SSP_T_ERASE_US,
   parameter int PAGE_WAIT_CYC = PAGE_WAIT_US * `SSP_CLK_MHZ,
   parameter int EEP_WAIT_CYC = EEP_WAIT_US * `SSP_CLK_MHZ,
   parameter int ERASE_WAIT_CYC = ERASE_WAIT_US * `SSP_CLK_MHZ,
   // identity bytes, values arbitrary
   parameter logic [7:0] SIG0 = 8'h5A,
   parameter logic [7:0] SIG1 = 8'h3C,
   parameter logic [7:0] SIG2 = 8'h0F
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // apb answer
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // programming pins
   input wire logic prog_rst_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe
);
   localparam int PW = `SSP_PG_BITS;
   localparam int FW = `SSP_PG_BITS + `SSP_PGN_BITS;
   localparam int EW = `SSP_EE_BITS;

   ssp_pkg::ssp_top_t r;
   ssp_pkg::ssp_top_t n;
   ssp_lnk_if lnk ();

   // memories; flash and eeprom contents are unknown until the first chip erase
   logic [15:0] flash [0:(2**FW)-1];
   logic [7:0] eeprom [0:(2**EW)-1];
   logic [7:0] pb_lo [0:(2**PW)-1];
   logic [7:0] pb_hi [0:(2**PW)-1];
   logic [7:0] ebuf [0:(2**`SSP_EPG_BITS)-1];

   // write ports, filled by the decoder and the background walk; then mode, busy, wait limit and read helpers
   logic fl_we;
   logic [FW-1:0] fl_a;
   logic [15:0] fl_wd;
   logic ee_we;
   logic [EW-1:0] ee_a;
   logic [7:0] ee_wd;
   logic pl_we;
   logic ph_we;
   logic eb_we;
   logic mode;
   logic pend;
   logic [17:0] lim;
   logic [7:0] rd_byte;
   logic [15:0] fl_rd;
   logic [PW-1:0] wi;

   ssp_shift u_shift (
      .pclk(pclk),
      .presetn(presetn),
      .sck(sck),
      .mosi(mosi),
      .lnk(lnk)
   );

   // port is live while the reset pin is low and software allows it
   assign mode = ~r.rst_s & r.port_en;
   assign pend = (r.st != ssp_pkg::SSP_ST_IDLE);
   assign wi = r.walk[PW-1:0];

   // read data for byte four, picked as byte three arrives
   always_comb begin
      fl_rd = flash[FW'({r.b2, lnk.rx_byte})];
      rd_byte = lnk.rx_byte;
      case (r.b1)
         `SSP_OP_POLL: rd_byte = {7'h00, pend};
         `SSP_OP_RD_PHI: rd_byte = fl_rd[15:8];
         `SSP_OP_RD_PLO: rd_byte = fl_rd[7:0];
         `SSP_OP_RD_EEP: rd_byte = eeprom[EW'({r.b2, lnk.rx_byte})];
         `SSP_OP_RD_LOCK: rd_byte = (r.b2 == `SSP_B2_HISEL) ? r.fhi : r.lock;
         `SSP_OP_RD_FUSE: rd_byte = (r.b2 == `SSP_B2_HISEL) ? r.fext : r.flo;
         `SSP_OP_RD_CAL: rd_byte = r.cal;
         `SSP_OP_RD_SIG: begin
            case (lnk.rx_byte[1:0])
               2'd0: rd_byte = SIG0;
               2'd1: rd_byte = SIG1;
               2'd2: rd_byte = SIG2;
               default: rd_byte = 8'hFF;
            endcase
         end
         default: rd_byte = lnk.rx_byte; // plain echo of the byte before
      endcase
      // reads other than poll before enable return only the echo of byte three
      if (!r.prog_en && r.b1 != `SSP_OP_POLL) begin
         rd_byte = lnk.rx_byte;
      end
   end

   // self-timed wait per operation
   always_comb begin
      case (r.op)
         ssp_pkg::SSP_OP_ERASE: lim = 18'(ERASE_WAIT_CYC - 1);
         ssp_pkg::SSP_OP_PAGE: lim = 18'(PAGE_WAIT_CYC - 1);
         default: lim = 18'(EEP_WAIT_CYC - 1);
      endcase
   end

   // next state
   always_comb begin
      n = r;
      fl_we = 1'b0;
      fl_a = '0;
      fl_wd = '0;
      ee_we = 1'b0;
      ee_a = '0;
      ee_wd = '0;
      pl_we = 1'b0;
      ph_we = 1'b0;
      eb_we = 1'b0;

      // reset pin through two flops
      n.rst_m = prog_rst_n;
      n.rst_s = r.rst_m;
      n.clr = ~mode;
      n.miso_oe = mode;
      // leaving the port drops the enable, so a new session must re-enable
      if (!mode) begin
         n.prog_en = 1'b0;
      end

      // apb: answer is prepared in the setup cycle, so access has no wait
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         n.pready = 1'b1;
         n.prdata = '0;
         case (paddr)
            `SSP_REG_CTRL: n.prdata = {16'h0000, r.cal, 7'h00, r.port_en};
            `SSP_REG_STAT: n.prdata = {8'h00, r.ext_adr, r.b1, 5'h00, pend, r.prog_en, mode};
            `SSP_REG_FUSE: n.prdata = {r.lock, r.fext, r.fhi, r.flo};
            default: n.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && r.pready && pwrite && paddr == `SSP_REG_CTRL) begin
         n.port_en = pwdata[0];
         n.cal = pwdata[15:8];
      end

      // background work and self-timed wait
      case (r.st)
         ssp_pkg::SSP_ST_IDLE: begin
            n.cnt = '0;
         end
         ssp_pkg::SSP_ST_WORK: begin
            n.cnt = r.cnt + 18'd1;
            n.walk = r.walk + 13'd1;
            case (r.op)
               ssp_pkg::SSP_OP_ERASE: begin
                  fl_we = 1'b1;
                  fl_a = r.walk;
                  fl_wd = {`SSP_ERASED, `SSP_ERASED};
                  ee_we = 1'b1;
                  ee_a = r.walk[EW-1:0];
                  ee_wd = `SSP_ERASED;
                  if (&r.walk) begin
                     n.st = ssp_pkg::SSP_ST_WAIT;
                  end
               end
               ssp_pkg::SSP_OP_PAGE: begin
                  fl_we = r.pmask[wi];
                  fl_a = {r.pg, wi};
                  fl_wd = {pb_hi[wi], pb_lo[wi]};
                  if (&wi) begin
                     n.pmask = '0;
                     n.st = ssp_pkg::SSP_ST_WAIT;
                  end
               end
               default: begin
                  // untouched slots of the page keep their data
                  ee_we = r.emask[r.walk[1:0]];
                  ee_a = {r.eaddr[EW-1:2], r.walk[1:0]};
                  ee_wd = ebuf[r.walk[1:0]];
                  if (&r.walk[1:0]) begin
                     n.emask = '0;
                     n.st = ssp_pkg::SSP_ST_WAIT;
                  end
               end
            endcase
         end
         ssp_pkg::SSP_ST_WAIT: begin
            n.cnt = r.cnt + 18'd1;
            if (r.cnt >= lim) begin
               n.st = ssp_pkg::SSP_ST_IDLE;
            end
         end
         default: begin
            n.st = ssp_pkg::SSP_ST_IDLE;
         end
      endcase

      // instruction bytes
      if (lnk.byte_vld && mode) begin
         case (lnk.byte_idx)
            2'd0: begin
               n.b1 = lnk.rx_byte;
               n.tx = lnk.rx_byte;
            end
            2'd1: begin
               n.b2 = lnk.rx_byte;
               n.tx = lnk.rx_byte; // second byte returns during the third
            end
            2'd2: begin
               n.b3 = lnk.rx_byte;
               n.tx = rd_byte;
            end
            default: begin
               n.tx = lnk.rx_byte;
               // enable is taken only once all four bytes are
               if (r.b1 == `SSP_OP_AC && r.b2 == `SSP_B2_EN) begin
                  n.prog_en = 1'b1;
               end else if (r.prog_en && !pend) begin
                  // writes while busy are dropped; poll first
                  case (r.b1)
                     `SSP_OP_AC: begin
                        case (r.b2)
                           `SSP_B2_ERASE: begin
                              n.st = ssp_pkg::SSP_ST_WORK;
                              n.op = ssp_pkg::SSP_OP_ERASE;
                              n.walk = '0;
                              n.lock = `SSP_LOCK_RST;
                           end
                           `SSP_B2_WLOCK: n.lock = r.lock & lnk.rx_byte; // only programs
                           `SSP_B2_WFLO: n.flo = lnk.rx_byte;
                           `SSP_B2_WFHI: n.fhi = lnk.rx_byte;
                           `SSP_B2_WFEXT: n.fext = lnk.rx_byte;
                           default: n.tx = lnk.rx_byte;
                        endcase
                     end
                     `SSP_OP_LD_EXT: n.ext_adr = r.b3;
                     `SSP_OP_LD_PLO: begin
                        pl_we = 1'b1;
                        n.pmask[r.b3[PW-1:0]] = 1'b1;
                     end
                     `SSP_OP_LD_PHI: begin
                        ph_we = 1'b1;
                        n.pmask[r.b3[PW-1:0]] = 1'b1;
                     end
                     `SSP_OP_LD_EEP: begin
                        eb_we = 1'b1;
                        n.emask[r.b3[1:0]] = 1'b1;
                     end
                     `SSP_OP_WR_PAGE: begin
                        // word address, page from its seven high bits
                        n.pg = {r.b2[4:0], r.b3[7:6]};
                        n.st = ssp_pkg::SSP_ST_WORK;
                        n.op = ssp_pkg::SSP_OP_PAGE;
                        n.walk = '0;
                     end
                     `SSP_OP_WR_EEP: begin
                        // overwrite is erase plus write inside the timed wait
                        ee_we = 1'b1;
                        ee_a = EW'({r.b2, r.b3});
                        ee_wd = lnk.rx_byte;
                        n.st = ssp_pkg::SSP_ST_WAIT;
                        n.op = ssp_pkg::SSP_OP_EEB;
                     end
                     `SSP_OP_WR_EPG: begin
                        n.eaddr = EW'({r.b2, r.b3});
                        n.st = ssp_pkg::SSP_ST_WORK;
                        n.op = ssp_pkg::SSP_OP_EEPG;
                        n.walk = '0;
                     end
                     default: n.tx = lnk.rx_byte;
                  endcase
               end
            end
         endcase
      end
   end

   // memory writes; arrays carry no reset
   always_ff @(posedge pclk) begin
      if (fl_we) begin
         flash[fl_a] <= fl_wd;
      end
      if (ee_we) begin
         eeprom[ee_a] <= ee_wd;
      end
      if (pl_we) begin
         pb_lo[r.b3[PW-1:0]] <= lnk.rx_byte;
      end
      if (ph_we) begin
         pb_hi[r.b3[PW-1:0]] <= lnk.rx_byte;
      end
      if (eb_we) begin
         ebuf[r.b3[1:0]] <= lnk.rx_byte;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.rst_m <= 1'b1;
         r.rst_s <= 1'b1;
         r.st <= ssp_pkg::SSP_ST_IDLE;
         r.op <= ssp_pkg::SSP_OP_ERASE;
         r.lock <= `SSP_LOCK_RST;
         r.flo <= `SSP_FUSE_RST;
         r.fhi <= `SSP_FUSE_RST;
         r.fext <= `SSP_FUSE_RST;
         r.port_en <= 1'b1;
         r.cal <= `SSP_CAL_RST;
         r.clr <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // outputs straight from flops
   assign lnk.tx_byte = r.tx;
   assign lnk.clr = r.clr;
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign miso = lnk.miso;
   assign miso_oe = r.miso_oe;
endmodule
`default_nettype wire

// file: pkg/ssp_defs.svh
// constants of the serial programming port
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
`define SSP_OP_AC 8'hAC
`define SSP_B2_EN 8'h53
`define SSP_B2_ERASE 8'h80
`define SSP_B2_WLOCK 8'hE0
`define SSP_B2_WFLO 8'hA0
`define SSP_B2_WFHI 8'hA8
`define SSP_B2_WFEXT 8'hA4
`define SSP_OP_POLL 8'hF0
`define SSP_OP_LD_EXT 8'h4D
`define SSP_OP_LD_PHI 8'h48
`define SSP_OP_LD_PLO 8'h40
`define SSP_OP_LD_EEP 8'hC1
`define SSP_OP_RD_PHI 8'h28
`define SSP_OP_RD_PLO 8'h20
`define SSP_OP_RD_EEP 8'hA0
`define SSP_OP_RD_LOCK 8'h58
`define SSP_OP_RD_FUSE 8'h50
`define SSP_B2_HISEL 8'h08
`define SSP_OP_RD_SIG 8'h30
`define SSP_OP_RD_CAL 8'h38
`define SSP_OP_WR_PAGE 8'h4C
`define SSP_OP_WR_EEP 8'hC0
`define SSP_OP_WR_EPG 8'hC2
`define SSP_ERASED 8'hFF
`define SSP_PG_BITS 6
`define SSP_PGN_BITS 7
`define SSP_EE_BITS 10
`define SSP_EPG_BITS 2
`define SSP_CLK_MHZ 25
`define SSP_T_PAGE_US 4500
`define SSP_T_EEP_US 3600
`define SSP_T_ERASE_US 9000
`define SSP_REG_CTRL 12'h000
`define SSP_REG_STAT 12'h004
`define SSP_REG_FUSE 12'h008
`define SSP_FUSE_RST 8'hFF
`define SSP_LOCK_RST 8'hFF
`define SSP_CAL_RST 8'h80
`endif

// file: pkg/ssp_lnk_if.sv
// byte link between the shift engine and the instruction decoder
`default_nettype none
interface ssp_lnk_if;
   logic byte_vld;
   logic [1:0] byte_idx;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic clr;
   logic miso;
   modport eng (output byte_vld, byte_idx, rx_byte, miso, input tx_byte, clr);
   modport ctl (input byte_vld, byte_idx, rx_byte, miso, output tx_byte, clr);
endinterface
`default_nettype wire

// file: pkg/ssp_pkg.sv
// types of the serial programming port
`include "ssp_defs.svh"
`default_nettype none
package ssp_pkg;
   typedef enum logic [2:0] {
      SSP_ST_IDLE = 3'b001,
      SSP_ST_WORK = 3'b010,
      SSP_ST_WAIT = 3'b100
   } ssp_st_t;
   typedef enum logic [1:0] {
      SSP_OP_ERASE = 2'b00,
      SSP_OP_PAGE = 2'b01,
      SSP_OP_EEB = 2'b10,
      SSP_OP_EEPG = 2'b11
   } ssp_op_t;
   typedef struct packed {
      logic sck_m;
      logic sck_s;
      logic sck_d;
      logic mosi_m;
      logic mosi_s;
      logic [2:0] bitc;
      logic [1:0] idx;
      logic [1:0] idx_o;
      logic [7:0] sh_in;
      logic [7:0] sh_out;
      logic [7:0] rx;
      logic vld;
      logic miso;
   } ssp_sh_t;
   typedef struct packed {
      logic rst_m;
      logic rst_s;
      ssp_st_t st;
      ssp_op_t op;
      logic prog_en;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] tx;
      logic [12:0] walk;
      logic [17:0] cnt;
      logic [7:0] ext_adr;
      logic [7:0] lock;
      logic [7:0] flo;
      logic [7:0] fhi;
      logic [7:0] fext;
      logic [63:0] pmask;
      logic [3:0] emask;
      logic [6:0] pg;
      logic [9:0] eaddr;
      logic [7:0] edata;
      logic port_en;
      logic [7:0] cal;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic miso_oe;
      logic clr;
   } ssp_top_t;
endpackage
`default_nettype wire

// file: tb/ssp_prog.sv
// programmer model: serial master that sends instructions and captures replies
`default_nettype none
module ssp_prog (
   // link pins
   output logic prog_rst_n,
   output logic sck,
   output logic mosi,
   input wire logic miso,
   // captured reply
   output logic [31:0] resp,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ns;
   // reset released and sck low from power-up
   initial begin
      prog_rst_n = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
      resp = '0;
      done = 1'b0;
   end
   // 32 bits msb first, 160 ns per phase, four cpu clocks
   task automatic xfer(input logic [31:0] c);
      #7;
      for (int i = 31; i >= 0; i--) begin
         mosi = c[i];
         #160 sck = 1'b1;
         #155 resp[i] = miso; // late in the high phase: miso moves only after a fall
         #5 sck = 1'b0;
      end
      mosi = ~c[0]; // released line must not keep showing the last bit
      done = 1'b1;
      #160 done = 1'b0;
   endtask
   // enter or leave the session; leaving also realigns framing
   task automatic session(input logic live);
      #3 prog_rst_n = ~live;
      #2000; // settle before the first instruction, scaled down
   endtask
endmodule
`default_nettype wire

// file: tb/ssp_top_assertions.sv
// concurrent checks on the apb answer and the programming pins
`default_nettype none
module ssp_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link
   input wire logic prog_rst_n,
   input wire logic sck,
   input wire logic miso,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic setup;
   logic unmapped;
   // decoded request, so that $past sees a plain signal
   assign setup = psel && !penable;
   assign unmapped = paddr > 12'h008;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   answer_next_a: assert property (setup |=> pready)
      else $error("no answer in the cycle after setup");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   pready_cause_a: assert property (pready |-> $past(setup))
      else $error("pready without a setup cycle");
   decode_err_a: assert property (setup && paddr[1:0] == 2'b00 |=> pslverr == $past(unmapped))
      else $error("error flag does not match the address map");
   refused_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused access returned data");
   // miso may only move a few clocks after a falling sck
   miso_edge_a: assert property ($changed(miso) && miso_oe && $past(miso_oe) |->
      $past(sck, 2) == 1'b0) else $error("miso moved while sck was high");
   oe_off_a: assert property (prog_rst_n [*5] |-> !miso_oe)
      else $error("port live outside device reset");
   oe_on_a: assert property ($rose(miso_oe) |-> !prog_rst_n && $past(prog_rst_n, 2) == 1'b0)
      else $error("port went live without device reset");
   cover property (pready && pslverr);
   cover property (pready && !pwrite && !pslverr);
   cover property ($rose(miso_oe));
endmodule
bind ssp_top ssp_chk u_ssp_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .prog_rst_n(prog_rst_n), .sck(sck), .miso(miso), .miso_oe(miso_oe));
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: apb registers and programming instructions over the link
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PW = 600;
   localparam int EW = 400;
   localparam int XW = 9000;
   localparam logic [7:0] SG[3] = '{8'h11, 8'h22, 8'h33}; // arbitrary identity bytes
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, miso, miso_oe;
   logic prog_rst_n, sck, mosi, done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, resp;
   logic [32:0] aq[$];
   logic [32:0] ae;
   logic [8:0] lq[$];
   logic [8:0] le;
   logic [31:0] rs = 32'd9398;
   logic [7:0] d0, d1, d2, cal;
   logic [7:0] fv[4];
   logic [6:0] pg;
   logic [7:0] wop[4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
   logic [15:0] rop[4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
   int bad_count = 0;
   int n_compared = 0;
   ssp_top #(.PAGE_WAIT_CYC(PW), .EEP_WAIT_CYC(EW), .ERASE_WAIT_CYC(XW), .SIG0(SG[0]),
      .SIG1(SG[1]), .SIG2(SG[2])) u_ssp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .prog_rst_n(prog_rst_n), .sck(sck), .mosi(mosi),
      .miso(miso), .miso_oe(miso_oe));
   ssp_prog u_ssp_prog (.prog_rst_n(prog_rst_n), .sck(sck), .mosi(mosi), .miso(miso),
      .resp(resp), .done(done));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no wait count assumed; only the watchdog ends a hung transfer
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      aq.push_back({(a > 12'h008), e}); // refused above the last register
      apb(1'b0, a, rnd());
   endtask
   // b3 set: compare reply byte three, else byte four
   task automatic ins(input logic [31:0] c, input logic b3, input logic [7:0] e);
      lq.push_back({b3, e});
      u_ssp_prog.xfer(c);
      repeat (8) @(posedge pclk);
   endtask
   // poll right after the operation, then again once the wait has run out
   task automatic op_wait(input int n);
      ins(32'hF000_0000, 1'b0, 8'h01);
      repeat (n) @(posedge pclk);
      ins(32'hF000_0000, 1'b0, 8'h00);
   endtask
   // read answers, sampled at the completing edge
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         ae = aq.pop_front();
         check("prdata", prdata, ae[31:0]);
         check("pslverr", {31'h0000_0000, pslverr}, {31'h0000_0000, ae[32]});
      end
   end
   // link replies, taken when the programmer finishes an instruction
   always @(posedge done) begin
      le = lq.pop_front();
      check("reply", le[8] ? resp[15:8] : resp[7:0], {24'h0, le[7:0]});
   end
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #3_000_000;
      bad_count++;
      conclude();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h000, 32'h0000_8001);
      rd(12'h008, 32'hFFFF_FFFF);
      rd(12'h00C, 32'h0000_0000); // unmapped
      cal = rnd();
      apb(1'b1, 12'h000, {16'h0000, cal, 8'h01});
      rd(12'h000, {16'h0000, cal, 8'h01});
      u_ssp_prog.session(1'b1);
      ins(32'hAC80_0000, 1'b0, 8'h00); // erase before enable must be refused
      ins(32'hF000_0000, 1'b0, 8'h00);
      ins(32'hAC53_0000, 1'b1, 8'h53);
      u_ssp_prog.session(1'b0); // resync pulse and retry
      u_ssp_prog.session(1'b1);
      ins(32'hAC53_0000, 1'b1, 8'h53);
      ins(32'hAC80_0000, 1'b0, 8'h00);
      op_wait(XW);
      ins(32'h2000_0500, 1'b0, 8'hFF);
      ins(32'hA000_0700, 1'b0, 8'hFF);
      pg = rnd();
      d0 = rnd();
      d1 = rnd();
      d2 = rnd();
      ins({16'h4000, 8'h03, d0}, 1'b0, 8'h03); // low before high
      ins({16'h4800, 8'h03, d1}, 1'b0, 8'h03);
      ins({16'h4000, 8'h3F, d1}, 1'b0, 8'h3F); // last slot of the page
      ins({8'h4C, 3'b000, pg, 6'h2A, 8'h00}, 1'b0, {pg[1:0], 6'h2A});
      op_wait(PW);
      ins({8'h20, 3'b000, pg, 6'h03, 8'h00}, 1'b0, d0);
      ins({8'h28, 3'b000, pg, 6'h03, 8'h00}, 1'b0, d1);
      ins({8'h20, 3'b000, pg, 6'h3F, 8'h00}, 1'b0, d1);
      ins({8'h20, 3'b000, pg, 6'h05, 8'h00}, 1'b0, 8'hFF);
      ins({8'hC0, 6'h00, 10'h2A3, d2}, 1'b0, 8'hA3);
      op_wait(EW);
      ins({8'hC0, 6'h00, 10'h2A3, ~d2}, 1'b0, 8'hA3); // overwrite without erase
      op_wait(EW);
      ins({8'hA0, 6'h00, 10'h2A3, 8'h00}, 1'b0, ~d2);
      ins({16'hC100, 8'h01, d0}, 1'b0, 8'h01);
      ins({8'hC2, 6'h00, 10'h2A0, 8'h00}, 1'b0, 8'hA0);
      op_wait(EW + 4);
      ins({8'hA0, 6'h00, 10'h2A1, 8'h00}, 1'b0, d0);
      ins({8'hA0, 6'h00, 10'h2A3, 8'h00}, 1'b0, ~d2);
      for (int k = 0; k < 4; k++) begin
         fv[k] = rnd();
         ins({8'hAC, wop[k], 8'h00, fv[k]}, 1'b0, 8'h00);
         ins({rop[k], 16'h0000}, 1'b0, fv[k]);
      end
      rd(12'h008, {fv[0], fv[3], fv[2], fv[1]});
      for (int k = 0; k < 3; k++) begin
         ins({16'h3000, 6'h00, k[1:0], 8'h00}, 1'b0, SG[k]);
      end
      ins(32'h3800_0000, 1'b0, cal);
      u_ssp_prog.session(1'b0);
      conclude();
   end
endmodule
`default_nettype wire
